// ===== verilog/cid_regs.vh
// constants for the instruction decode and execute core
`ifndef CID_REGS_VH
`define CID_REGS_VH

// data space map
`define CID_ADDR_ACC     8'hFF
`define CID_SHORT_HI     6'h20
`define CID_RESET_PC     12'h000

// opcode group, op[7:5]
`define CID_GRP_BNZ      3'h0
`define CID_GRP_BNC      3'h1
`define CID_GRP_BZ       3'h2
`define CID_GRP_BC       3'h3
`define CID_GRP_JMP      3'h4
`define CID_GRP_BIT      3'h5
`define CID_GRP_IND      3'h6
`define CID_GRP_DIR      3'h7

// memory operation, op[2:0] in indirect and direct forms
`define CID_OP_LDA       3'h0
`define CID_OP_STA       3'h1
`define CID_OP_ADD       3'h2
`define CID_OP_AND       3'h3
`define CID_OP_CMP       3'h4
`define CID_OP_SUB       3'h5
`define CID_OP_INC       3'h6
`define CID_OP_DEC       3'h7

// immediate forms reuse the codes above, with these in place of codes 1, 6 and 7
`define CID_IMM_LDR      3'h1
`define CID_IMM_CLR      3'h6
`define CID_IMM_RSV      3'h7

// inherent accumulator forms, op[2:0]
`define CID_INH_COM      3'h0
`define CID_INH_RLC      3'h1
`define CID_INH_SLA      3'h2
`define CID_INH_CLRA     3'h3

// short direct operation, op[3:2]
`define CID_SD_LDA       2'h0
`define CID_SD_STA       2'h1
`define CID_SD_INC       2'h2
`define CID_SD_DEC       2'h3

// bit group operation, op[4:3]
`define CID_BIT_SET      2'h0
`define CID_BIT_CLR      2'h1
`define CID_BIT_TBC      2'h2
`define CID_BIT_TBS      2'h3

// cycle counts and lengths
`define CID_CYC_BRANCH   3'h2
`define CID_CYC_STD      3'h4
`define CID_CYC_BTST     3'h5
`define CID_BTST_BASE    12'h002
`define CID_STACK_LAST   3'h5

`endif

// ===== verilog/cid_core.v
// instruction decode and execute core
`timescale 1ns/100ps
`default_nettype none
`include "cid_regs.vh"

module cid_core (
  input  wire        CLK_I,
  input  wire        RST_N_I,
  output wire [11:0] PM_ADDR_O,
  input  wire [7:0]  PM_DATA_I,
  output wire [7:0]  DS_ADDR_O,
  output wire        DS_RD_O,
  input  wire [7:0]  DS_RDATA_I,
  output wire        DS_WE_O,
  output wire [7:0]  DS_WDATA_O,
  output wire [11:0] PC_O,
  output wire [7:0]  ACC_O,
  output wire        ZERO_O,
  output wire        CARRY_O,
  output wire        DONE_O
);

  reg  [11:0] pc_reg;
  reg  [11:0] fetch_reg;
  reg  [2:0]  cyc_reg;
  reg  [7:0]  op_reg;
  reg  [7:0]  b2_reg;
  reg  [7:0]  b3_reg;
  reg  [7:0]  acc_reg;
  reg         z_reg;
  reg         c_reg;
  reg  [7:0]  ds_addr_reg;
  reg         ds_rd_reg;
  reg         ds_we_reg;
  reg  [7:0]  ds_wdata_reg;
  reg         done_reg;
  reg  [11:0] stack_mem [0:5];
  reg  [2:0]  sp_reg;
  wire [7:0]  sreg [0:3];

  // combinational execute results
  reg  [7:0]  acc_next;
  reg         z_next;
  reg         c_next;
  reg  [11:0] pc_next;
  reg         wr_req;
  reg  [7:0]  wr_data;
  reg         push;
  reg  [7:0]  src;
  reg  [2:0]  sub;
  reg  [8:0]  sum;
  reg  [8:0]  diff;
  reg         bitval;
  reg  [7:0]  mask;
  wire [2:0]  grp   = op_reg[7:5];
  wire [2:0]  tot   = cid_cycles(op_reg);
  wire        exec  = (cyc_reg != 3'h0) && (cyc_reg == tot - 3'h1);
  wire        addrc = (cyc_reg != 3'h0) && (cyc_reg == tot - 3'h2);
  wire [7:0]  daddr = cid_daddr(op_reg, b2_reg, sreg[0], sreg[1]);
  wire        hit   = cid_internal(ds_addr_reg);
  // internal registers answer locally so the pointers are usable next cycle
  wire [7:0]  opd   = !hit ? DS_RDATA_I :
                      (ds_addr_reg == `CID_ADDR_ACC) ? acc_reg : sreg[ds_addr_reg[1:0]];
  wire        imm   = (grp == `CID_GRP_DIR) && !op_reg[4] && op_reg[3];
  wire        inh   = (grp == `CID_GRP_IND) && op_reg[3];
  wire [11:0] pc_seq = pc_reg + {10'h000, cid_bytes(op_reg)};
  wire        take  = ((op_reg[5] ? c_reg : z_reg) == op_reg[6]);
  // cycles per instruction
  function [2:0] cid_cycles;
    input [7:0] op;
    begin
      case (op[7:5])
        `CID_GRP_BNZ, `CID_GRP_BNC, `CID_GRP_BZ, `CID_GRP_BC: cid_cycles = `CID_CYC_BRANCH;
        `CID_GRP_BIT: cid_cycles = op[4] ? `CID_CYC_BTST : `CID_CYC_STD;
        default: cid_cycles = `CID_CYC_STD;
      endcase
    end
  endfunction
  // encoded length in bytes
  function [1:0] cid_bytes;
    input [7:0] op;
    begin
      case (op[7:5])
        `CID_GRP_BNZ, `CID_GRP_BNC, `CID_GRP_BZ, `CID_GRP_BC: cid_bytes = 2'h1;
        `CID_GRP_JMP: cid_bytes = 2'h2;
        `CID_GRP_BIT: cid_bytes = op[4] ? 2'h3 : 2'h2;
        `CID_GRP_IND: cid_bytes = (op[3] && (op[2:0] == `CID_INH_SLA || op[2:0] == `CID_INH_CLRA)) ?
                                  2'h2 : 2'h1;
        default: cid_bytes = op[4] ? 2'h1 :
            (op[3] && (op[2:0] == `CID_IMM_LDR || op[2:0] == `CID_IMM_CLR)) ? 2'h3 : 2'h2;
      endcase
    end
  endfunction
  // data space address of the operand
  function [7:0] cid_daddr;
    input [7:0] op;
    input [7:0] b2;
    input [7:0] ptr_a;
    input [7:0] ptr_b;
    begin
      case (op[7:5])
        `CID_GRP_IND: cid_daddr = op[3] ? `CID_ADDR_ACC : (op[4] ? ptr_b : ptr_a);
        `CID_GRP_DIR: cid_daddr = op[4] ? {`CID_SHORT_HI, op[1:0]} :
            (op[3] && op[2:0] != `CID_IMM_LDR && op[2:0] != `CID_IMM_CLR) ? `CID_ADDR_ACC : b2;
        default: cid_daddr = b2;
      endcase
    end
  endfunction

  function cid_internal;
    input [7:0] a;
    begin
      cid_internal = (a[7:2] == `CID_SHORT_HI) || (a == `CID_ADDR_ACC);
    end
  endfunction

  always @* begin
    acc_next = acc_reg;
    z_next   = z_reg;
    c_next   = c_reg;
    pc_next  = pc_seq;
    wr_req   = 1'b0;
    wr_data  = 8'h00;
    push     = 1'b0;
    src      = imm ? b2_reg : opd;
    sub      = op_reg[2:0];
    sum      = {1'b0, acc_reg} + {1'b0, src};
    diff     = {1'b0, acc_reg} - {1'b0, src};
    bitval   = opd[op_reg[2:0]];
    mask     = 8'h01 << op_reg[2:0];
    case (grp)
      `CID_GRP_BNZ, `CID_GRP_BNC, `CID_GRP_BZ, `CID_GRP_BC: begin
        if (take) begin
          // forward reaches +1..+16, backward 0..-15
          pc_next = op_reg[4] ? pc_reg - {8'h00, op_reg[3:0]} :
                    pc_reg + 12'h001 + {8'h00, op_reg[3:0]};
        end
      end
      `CID_GRP_JMP: begin
        pc_next = {op_reg[3:0], b2_reg};
        push    = op_reg[4];
      end
      `CID_GRP_BIT: begin
        case (op_reg[4:3])
          `CID_BIT_SET: begin
            wr_req  = 1'b1;
            wr_data = opd | mask;
          end
          `CID_BIT_CLR: begin
            wr_req  = 1'b1;
            wr_data = opd & ~mask;
          end
          default: begin
            c_next = bitval;
            if (bitval == op_reg[3])
              pc_next = pc_reg + `CID_BTST_BASE + {{4{b3_reg[7]}}, b3_reg};
          end
        endcase
      end
      default: begin
        if (inh) begin
          case (sub)
            `CID_INH_COM: begin
              acc_next = ~acc_reg;
              c_next   = acc_reg[7];
            end
            `CID_INH_RLC: {c_next, acc_next} = {acc_reg, c_reg};
            `CID_INH_SLA: {c_next, acc_next} = {acc_reg, 1'b0};
            `CID_INH_CLRA: begin
              acc_next = 8'h00;
              c_next   = 1'b0;
            end
            default: acc_next = acc_reg;
          endcase
          if (sub[2] == 1'b0)
            z_next = (acc_next == 8'h00);
        end else if (imm && (sub == `CID_IMM_LDR || sub == `CID_IMM_CLR || sub == `CID_IMM_RSV)) begin
          wr_req  = (sub != `CID_IMM_RSV);
          wr_data = (sub == `CID_IMM_LDR) ? b3_reg : 8'h00;
        end else begin
          // short codes 0..3 land on load, store, inc 6 and dec 7
          if (grp == `CID_GRP_DIR && op_reg[4])
            sub = {op_reg[3], op_reg[3], op_reg[2]};
          case (sub)
            `CID_OP_LDA: begin
              acc_next = src;
              z_next   = (src == 8'h00);
            end
            `CID_OP_STA: begin
              wr_req  = 1'b1;
              wr_data = acc_reg;
              z_next  = (acc_reg == 8'h00);
            end
            `CID_OP_ADD: begin
              acc_next = sum[7:0];
              c_next   = sum[8];
              z_next   = (sum[7:0] == 8'h00);
            end
            `CID_OP_AND: begin
              acc_next = acc_reg & src;
              c_next   = 1'b0;
              z_next   = ((acc_reg & src) == 8'h00);
            end
            `CID_OP_CMP: begin
              c_next = diff[8];
              z_next = (diff[7:0] == 8'h00);
            end
            `CID_OP_SUB: begin
              acc_next = diff[7:0];
              c_next   = diff[8];
              z_next   = (diff[7:0] == 8'h00);
            end
            default: begin
              wr_req  = 1'b1;
              wr_data = (sub == `CID_OP_INC) ? opd + 8'h01 : opd - 8'h01;
              z_next  = (wr_data == 8'h00);
            end
          endcase
        end
      end
    endcase
  end

  // short direct registers, pointers at the first two slots
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sreg
      reg [7:0] val_reg;
      always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I)
          val_reg <= 8'h00;
        else if (exec && wr_req && ds_addr_reg == {`CID_SHORT_HI, gi[1:0]})
          val_reg <= wr_data;
      end
      assign sreg[gi] = val_reg;
    end
  endgenerate

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pc_reg       <= `CID_RESET_PC;
      fetch_reg    <= `CID_RESET_PC;
      cyc_reg      <= 3'h0;
      op_reg       <= 8'h00;
      b2_reg       <= 8'h00;
      b3_reg       <= 8'h00;
      acc_reg      <= 8'h00;
      z_reg        <= 1'b0;
      c_reg        <= 1'b0;
      ds_addr_reg  <= 8'h00;
      ds_rd_reg    <= 1'b0;
      ds_we_reg    <= 1'b0;
      ds_wdata_reg <= 8'h00;
      done_reg     <= 1'b0;
      sp_reg       <= 3'h0;
    end else begin
      ds_rd_reg <= 1'b0;
      ds_we_reg <= 1'b0;
      done_reg  <= exec;
      if (cyc_reg == 3'h0) begin
        op_reg    <= PM_DATA_I;
        cyc_reg   <= 3'h1;
        fetch_reg <= fetch_reg + 12'h001;
      end else begin
        if (cyc_reg == 3'h1)
          b2_reg <= PM_DATA_I;
        if (cyc_reg == 3'h2)
          b3_reg <= PM_DATA_I;
        if (addrc) begin
          ds_addr_reg <= daddr;
          ds_rd_reg   <= !cid_internal(daddr) && grp != `CID_GRP_JMP;
        end
        if (exec) begin
          cyc_reg   <= 3'h0;
          pc_reg    <= pc_next;
          fetch_reg <= pc_next;
          z_reg     <= z_next;
          c_reg     <= c_next;
          // accumulator as a direct destination takes the written byte
          acc_reg   <= (wr_req && ds_addr_reg == `CID_ADDR_ACC) ? wr_data : acc_next;
          // external write lands during the next fetch, before any later read
          ds_we_reg    <= wr_req && !hit;
          ds_wdata_reg <= wr_data;
          if (push) begin
            stack_mem[sp_reg] <= pc_seq;
            // overflow wraps and overwrites the oldest entry
            sp_reg <= (sp_reg == `CID_STACK_LAST) ? 3'h0 : sp_reg + 3'h1;
          end
        end else begin
          cyc_reg   <= cyc_reg + 3'h1;
          fetch_reg <= fetch_reg + 12'h001;
        end
      end
    end
  end

  assign PM_ADDR_O  = fetch_reg;
  assign DS_ADDR_O  = ds_addr_reg;
  assign DS_RD_O    = ds_rd_reg;
  assign DS_WE_O    = ds_we_reg;
  assign DS_WDATA_O = ds_wdata_reg;
  assign PC_O       = pc_reg;
  assign ACC_O      = acc_reg;
  assign ZERO_O     = z_reg;
  assign CARRY_O    = c_reg;
  assign DONE_O     = done_reg;

endmodule

`default_nettype wire

// ===== testbench/cid_core_chk.sv
// port assertions for the instruction core
`timescale 1ns/100ps
`default_nettype none
module cid_core_chk (
  input wire        CLK_I,
  input wire        RST_N_I,
  input wire [11:0] PM_ADDR_O,
  input wire [7:0]  PM_DATA_I,
  input wire [7:0]  DS_ADDR_O,
  input wire        DS_RD_O,
  input wire        DS_WE_O,
  input wire [11:0] PC_O,
  input wire        ZERO_O,
  input wire        CARRY_O,
  input wire        DONE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  done_pulse_a: assert property (DONE_O |=> !DONE_O)
    else $error("done held two cycles");
  write_pair_a: assert property (DS_WE_O |-> DONE_O && $past(DS_RD_O))
    else $error("write without read cycle");
  addr_hold_a: assert property (DS_WE_O |-> $stable(DS_ADDR_O))
    else $error("address moved during write");
  internal_regs_a: assert property (DS_RD_O |-> DS_ADDR_O < 8'h80 || (DS_ADDR_O > 8'h83 && DS_ADDR_O != 8'hFF))
    else $error("strobe on internal address");
  pc_reload_a: assert property (DONE_O |-> PC_O == PM_ADDR_O)
    else $error("pc and fetch address differ");
  fetch_step_a: assert property (!DONE_O && $past(RST_N_I) |-> PM_ADDR_O == $past(PM_ADDR_O) + 12'h001 && $stable(PC_O))
    else $error("fetch address did not step");
  short_branch_a: assert property (DONE_O && !PM_DATA_I[7] |=> !DONE_O ##1 DONE_O && $stable(ZERO_O) && $stable(CARRY_O))
    else $error("short branch length or flags");
  zero_taken_a: assert property (DONE_O && PM_DATA_I[7:4] == 4'h4 && ZERO_O
    |=> ##1 PC_O == $past(PC_O, 2) + 12'h001 + {8'h00, $past(PM_DATA_I[3:0], 2)})
    else $error("zero branch target");
  nonzero_skip_a: assert property (DONE_O && PM_DATA_I[7:5] == 3'h0 && ZERO_O |=> ##1 PC_O == $past(PC_O, 2) + 12'h001)
    else $error("untaken branch moved");
  bit_test_a: assert property (DONE_O && PM_DATA_I[7:4] == 4'hB |=> !DONE_O [*4] ##1 DONE_O && $stable(ZERO_O))
    else $error("bit test length or zero");
  long_jump_a: assert property (DONE_O && PM_DATA_I[7:5] == 3'h4
    |=> !DONE_O [*3] ##1 DONE_O && PC_O == {$past(PM_DATA_I[3:0], 4), $past(PM_DATA_I, 3)})
    else $error("long jump target");
endmodule
bind cid_core cid_core_chk chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PM_ADDR_O(PM_ADDR_O), .PM_DATA_I(PM_DATA_I),
  .DS_ADDR_O(DS_ADDR_O), .DS_RD_O(DS_RD_O), .DS_WE_O(DS_WE_O), .PC_O(PC_O), .ZERO_O(ZERO_O),
  .CARRY_O(CARRY_O), .DONE_O(DONE_O));
`default_nettype wire

// ===== testbench/cid_mem.sv
// program and data space memory model
`timescale 1ns/100ps
`default_nettype none
module cid_mem (
  input  wire        clk_i,
  input  wire [11:0] pm_addr_i,
  output wire [7:0]  pm_data_o,
  input  wire [7:0]  ds_addr_i,
  input  wire        ds_rd_i,
  output wire [7:0]  ds_rdata_o,
  input  wire        ds_we_i,
  input  wire [7:0]  ds_wdata_i
);
  logic [7:0] pm [0:4095];
  logic [7:0] ds [0:255];
  initial begin
    foreach (pm[i]) pm[i] = 8'hDC;
    foreach (ds[i]) ds[i] = 8'h00;
  end
  assign pm_data_o = pm[pm_addr_i];
  // unselected bus shows inverted data so a stray sample cannot match
  assign ds_rdata_o = ds_rd_i ? ds[ds_addr_i] : ~ds[ds_addr_i];
  always @(posedge clk_i) begin
    if (ds_we_i) begin
      ds[ds_addr_i] <= ds_wdata_i;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/cid_core_test.sv
// self-checking bench for the instruction core
`timescale 1ns/100ps
`default_nettype none
module cid_core_test;
  logic        clk;
  logic        rst_n;
  wire  [11:0] pm_addr;
  wire  [7:0]  pm_data;
  wire  [7:0]  ds_addr;
  wire         ds_rd;
  wire  [7:0]  ds_rdata;
  wire         ds_we;
  wire  [7:0]  ds_wdata;
  wire  [11:0] pc;
  wire  [7:0]  acc;
  wire         zero;
  wire         carry;
  wire         done;
  int          errors;
  int          comparisons;
  int          ticks;
  int          k;
  logic [11:0] wp;
  logic [11:0] qpc [0:31];
  logic [7:0]  qa [0:31];
  logic [1:0]  qzc [0:31];
  int          qcy [0:31];

  cid_core dut (.CLK_I(clk), .RST_N_I(rst_n), .PM_ADDR_O(pm_addr), .PM_DATA_I(pm_data), .DS_ADDR_O(ds_addr),
    .DS_RD_O(ds_rd), .DS_RDATA_I(ds_rdata), .DS_WE_O(ds_we), .DS_WDATA_O(ds_wdata), .PC_O(pc), .ACC_O(acc),
    .ZERO_O(zero), .CARRY_O(carry), .DONE_O(done));
  cid_mem mem (.clk_i(clk), .pm_addr_i(pm_addr), .pm_data_o(pm_data), .ds_addr_i(ds_addr), .ds_rd_i(ds_rd),
    .ds_rdata_o(ds_rdata), .ds_we_i(ds_we), .ds_wdata_i(ds_wdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // every test is far shorter than this
  always @(posedge clk) begin
    ticks++;
    if (ticks > 2000) begin
      errors++;
      final_report;
    end
  end

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // queue one instruction; j below zero means fall through
  task automatic op(input int n, input [23:0] b, input int cy, input [7:0] a, input [1:0] zc, input int j);
    mem.pm[wp] = b[23:16];
    if (n > 1) mem.pm[12'(wp + 1)] = b[15:8];
    if (n > 2) mem.pm[12'(wp + 2)] = b[7:0];
    wp = (j < 0) ? 12'(wp + n) : 12'(j);
    qpc[k] = wp;
    qa[k] = a;
    qzc[k] = zc;
    qcy[k] = cy;
    k++;
  endtask

  task automatic run;
    int n;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset addr", pm_addr, 12'h000);
    chk("reset acc", {4'h0, acc}, 12'h000);
    rst_n = 1'b1;
    for (int i = 0; i < k; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (done !== 1'b1 && n < 20);
      chk("cycles", 12'(n), 12'(qcy[i]));
      chk("pc", pc, qpc[i]);
      chk("acc", {4'h0, acc}, {4'h0, qa[i]});
      chk("flags", {10'h000, zero, carry}, {10'h000, qzc[i]});
    end
    @(posedge clk);
    #1;
    k = 0;
    wp = 12'h000;
  endtask

  task automatic t_ldst;
    op(2, 24'hE80000, 4, 8'h00, 2'h2, -1);
    op(3, 24'hE9405A, 4, 8'h00, 2'h2, -1);
    op(2, 24'hE04000, 4, 8'h5A, 2'h0, -1);
    op(1, 24'hF60000, 4, 8'h5A, 2'h0, -1);
    op(3, 24'hE98041, 4, 8'h5A, 2'h0, -1);
    op(1, 24'hC10000, 4, 8'h5A, 2'h0, -1);
    run;
    chk("ds 40", {4'h0, mem.ds[8'h40]}, 12'h05A);
    chk("ds 41", {4'h0, mem.ds[8'h41]}, 12'h05A);
    $display("test load store done");
  endtask

  task automatic t_alu;
    mem.ds[8'h40] = 8'hFF;
    mem.ds[8'h42] = 8'h77;
    op(2, 24'hE8F000, 4, 8'hF0, 2'h0, -1);
    op(2, 24'hEA2000, 4, 8'h10, 2'h1, -1);
    op(2, 24'hEC1000, 4, 8'h10, 2'h2, -1);
    op(2, 24'hED1100, 4, 8'hFF, 2'h1, -1);
    op(2, 24'hEB0F00, 4, 8'h0F, 2'h0, -1);
    op(1, 24'hD80000, 4, 8'hF0, 2'h0, -1);
    op(1, 24'hD90000, 4, 8'hE0, 2'h1, -1);
    op(2, 24'hDA0000, 4, 8'hC0, 2'h1, -1);
    op(2, 24'hDB0000, 4, 8'h00, 2'h2, -1);
    op(2, 24'hE8FF00, 4, 8'hFF, 2'h0, -1);
    op(2, 24'hEA0100, 4, 8'h00, 2'h3, -1);
    op(2, 24'hE64000, 4, 8'h00, 2'h3, -1);
    op(1, 24'hFF0000, 4, 8'h00, 2'h1, -1);
    op(3, 24'hEE4200, 4, 8'h00, 2'h1, -1);
    run;
    chk("ds 40", {4'h0, mem.ds[8'h40]}, 12'h000);
    chk("ds 42", {4'h0, mem.ds[8'h42]}, 12'h000);
    $display("test arithmetic done");
  endtask

  task automatic t_branch;
    mem.ds[8'h40] = 8'h80;
    op(2, 24'hE80000, 4, 8'h00, 2'h2, -1);
    op(1, 24'h430000, 2, 8'h00, 2'h2, 6);
    op(1, 24'h020000, 2, 8'h00, 2'h2, -1);
    op(1, 24'h340000, 2, 8'h00, 2'h2, 3);
    op(1, 24'h600000, 2, 8'h00, 2'h2, -1);
    op(2, 24'h801000, 4, 8'h00, 2'h2, 16);
    op(3, 24'hBF4010, 5, 8'h00, 2'h3, 34);
    op(1, 24'h750000, 2, 8'h00, 2'h3, 29);
    op(3, 24'hB040F0, 5, 8'h00, 2'h2, 15);
    op(1, 24'h3F0000, 2, 8'h00, 2'h2, 0);
    run;
    $display("test branch done");
  endtask

  task automatic t_bit;
    mem.ds[8'h40] = 8'hFF;
    mem.ds[8'h41] = 8'h00;
    op(2, 24'hA34100, 4, 8'h00, 2'h0, -1);
    op(2, 24'hAF4000, 4, 8'h00, 2'h0, -1);
    op(2, 24'hA08200, 4, 8'h00, 2'h0, -1);
    op(1, 24'hF20000, 4, 8'h01, 2'h0, -1);
    op(3, 24'hE98141, 4, 8'h01, 2'h0, -1);
    op(1, 24'hD00000, 4, 8'h08, 2'h0, -1);
    op(2, 24'h934500, 4, 8'h08, 2'h0, 12'h345);
    op(2, 24'h8ABC00, 4, 8'h08, 2'h0, 12'hABC);
    run;
    chk("ds 40", {4'h0, mem.ds[8'h40]}, 12'h07F);
    chk("ds 41", {4'h0, mem.ds[8'h41]}, 12'h008);
    $display("test bit ops done");
  endtask

  initial begin
    rst_n = 1'b0;
    errors = 0;
    comparisons = 0;
    ticks = 0;
    k = 0;
    wp = 12'h000;
    @(posedge clk);
    #1;
    t_ldst;
    t_alu;
    t_branch;
    t_bit;
    final_report;
  end
endmodule
`default_nettype wire
